// ### lcs_pkg.sv
// Package with register map, field layout and constants of the latching control switch bank.
package lcs_pkg;
  localparam int NUM_SWITCHES = 5;
  localparam int LABEL_CHARS = 32;
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_STATE = 8'h00;
  localparam logic [7:0] ADDR_EVT_FILTER = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0c;
  localparam logic [7:0] ADDR_EVT_CODE = 8'h10;
  localparam logic [7:0] ADDR_EVT_STAMP = 8'h14;
  localparam logic [7:0] ADDR_TIME = 8'h18;
  localparam logic [7:0] ADDR_LEVEL = 8'h1c;
  localparam logic [7:0] ADDR_LABEL_BASE = 8'h40;
  // Five labels of thirty-two bytes each fill the window up to 0xdf.
  localparam logic [7:0] ADDR_LABEL_END = 8'he0;
  localparam logic [1:0] LEVEL_USER = 2'h0;
  localparam logic [1:0] LEVEL_OPERATOR = 2'h1;
  localparam logic [1:0] LEVEL_CONFIGURATOR = 2'h2;
  localparam logic [1:0] LEVEL_SUPER = 2'h3;
  localparam logic [1:0] LEVEL_RESET = LEVEL_CONFIGURATOR;
  localparam logic [1:0] FILTER_BOTH = 2'h0;
  localparam logic [1:0] FILTER_ON_ONLY = 2'h1;
  localparam logic [1:0] FILTER_OFF_ONLY = 2'h2;
  localparam logic [1:0] FILTER_RESET = FILTER_BOTH;
  localparam int IRQ_EVENT_BIT = 0;
  localparam int IRQ_REJECT_BIT = 1;
  localparam int IRQ_OVERRUN_BIT = 2;
  localparam int IRQ_W = 3;
endpackage : lcs_pkg

// ### lcs_event_stamp.sv
// Event stamp unit: free-running time base and capture of one filtered switch event.
`timescale 1ns/1ns
module lcs_event_stamp #(
  parameter int NUM_SW = 5,
  parameter int TIME_W = 32
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [NUM_SW-1:0] rise,
  input wire logic [NUM_SW-1:0] fall,
  input wire logic [1:0] filter_sel,
  input wire logic taken,
  output logic evt_valid,
  output logic [3:0] evt_code,
  output logic [TIME_W-1:0] evt_stamp,
  output logic [TIME_W-1:0] time_now,
  output logic overrun
);
  logic [TIME_W-1:0] time_reg;
  logic [NUM_SW-1:0] keep;
  logic any_keep;
  logic [3:0] code_sel;
  logic [TIME_W-1:0] time_next;

  // Filter each edge kind by the selection, both kinds pass by default.
  wire keep_on = (filter_sel != lcs_pkg::FILTER_OFF_ONLY);
  wire keep_off = (filter_sel != lcs_pkg::FILTER_ON_ONLY);
  genvar g;
  generate
    for (g = 0; g < NUM_SW; g = g + 1) begin : g_keep
      assign keep[g] = (rise[g] & keep_on) | (fall[g] & keep_off);
    end
  endgenerate
  assign any_keep = |keep;
  assign time_next = time_reg + {{(TIME_W-1){1'b0}}, 1'b1};

  // Code is switch index times two plus one for OFF; lowest switch wins a tie.
  always_comb begin
    code_sel = 4'h0;
    for (int i = NUM_SW - 1; i >= 0; i = i - 1) begin
      if (keep[i]) begin
        code_sel = {i[2:0], fall[i]};
      end
    end
  end

  assign time_now = time_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      time_reg <= '0;
      evt_valid <= 1'b0;
      evt_code <= 4'h0;
      evt_stamp <= '0;
      overrun <= 1'b0;
    end else if (clk_en) begin
      time_reg <= time_next;
      overrun <= any_keep & evt_valid & ~taken;
      if (any_keep) begin
        evt_valid <= 1'b1;
        evt_code <= code_sel;
        evt_stamp <= time_reg;
      end else if (taken) begin
        evt_valid <= 1'b0;
      end
    end
  end
endmodule : lcs_event_stamp

// ### lcs_switch_bank.sv
// Top module: latching control switch bank with Wishbone slave and interrupt.
`timescale 1ns/1ns
module lcs_switch_bank #(
  parameter int NUM_SW = lcs_pkg::NUM_SWITCHES,
  parameter int TIME_W = 32
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic local_cmd_valid,
  input wire logic [2:0] local_cmd_switch,
  input wire logic local_cmd_on,
  input wire logic [1:0] local_session_level,
  input wire logic remote_cmd_valid,
  input wire logic [2:0] remote_cmd_switch,
  input wire logic remote_cmd_on,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic [NUM_SW-1:0] switch_out,
  output logic local_cmd_reject,
  output logic event_irq
);
  // Switch state and settings.
  logic [NUM_SW-1:0] state_reg;
  logic [NUM_SW-1:0] state_next;
  logic [NUM_SW-1:0] rise;
  logic [NUM_SW-1:0] fall;
  logic [2*NUM_SW-1:0] level_reg;
  logic [1:0] filter_reg;
  logic [lcs_pkg::IRQ_W-1:0] irq_status_reg;
  logic [lcs_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [lcs_pkg::IRQ_W-1:0] irq_set;
  logic [7:0] label_mem [0:NUM_SW*lcs_pkg::LABEL_CHARS-1];
  logic evt_valid;
  logic [3:0] evt_code;
  logic [TIME_W-1:0] evt_stamp;
  logic [TIME_W-1:0] time_now;
  logic overrun;
  logic [31:0] rd_data;
  logic [31:0] label_word;
  logic [1:0] level_of_local;

  // Local panel command handling with access check.
  wire local_in_range = (local_cmd_switch < 3'(NUM_SW));
  wire remote_in_range = (remote_cmd_switch < 3'(NUM_SW));
  always_comb begin
    level_of_local = lcs_pkg::LEVEL_RESET;
    for (int i = 0; i < NUM_SW; i = i + 1) begin
      if (local_cmd_switch == 3'(i)) begin
        level_of_local = level_reg[2*i +: 2];
      end
    end
  end
  // A session below the switch's required level is turned away.
  wire local_ok = local_cmd_valid & local_in_range & (local_session_level >= level_of_local);
  wire local_rej = local_cmd_valid & ~local_ok;
  wire remote_ok = remote_cmd_valid & remote_in_range;

  // Only these two sources enter the next-state logic; nothing else can move a switch.
  // Remote is applied after local, so when both hit one switch in a cycle remote wins.
  always_comb begin
    state_next = state_reg;
    if (local_ok) begin
      state_next[local_cmd_switch] = local_cmd_on;
    end
    if (remote_ok) begin
      state_next[remote_cmd_switch] = remote_cmd_on;
    end
  end

  // A same-state command leaves state_next equal and so gives no edge.
  assign rise = state_next & ~state_reg;
  assign fall = ~state_next & state_reg;

  // Wishbone decode.
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire wr = wb_req & wb_we_i;
  wire rd_evt = wb_req & ~wb_we_i & (wb_adr_i == lcs_pkg::ADDR_EVT_CODE);
  wire in_label = (wb_adr_i >= lcs_pkg::ADDR_LABEL_BASE) & (wb_adr_i < lcs_pkg::ADDR_LABEL_END);
  wire [5:0] label_wi = 6'(wb_adr_i[7:2] - lcs_pkg::ADDR_LABEL_BASE[7:2]);
  wire label_hit = in_label & (label_wi < 6'(NUM_SW * lcs_pkg::LABEL_CHARS / 4));
  wire [7:0] label_base = {label_wi, 2'b00};
  wire mapped = label_hit | (wb_adr_i == lcs_pkg::ADDR_STATE)
    | (wb_adr_i == lcs_pkg::ADDR_EVT_FILTER) | (wb_adr_i == lcs_pkg::ADDR_IRQ_STATUS)
    | (wb_adr_i == lcs_pkg::ADDR_IRQ_MASK) | (wb_adr_i == lcs_pkg::ADDR_EVT_CODE)
    | (wb_adr_i == lcs_pkg::ADDR_EVT_STAMP) | (wb_adr_i == lcs_pkg::ADDR_TIME)
    | (wb_adr_i == lcs_pkg::ADDR_LEVEL);
  wire wr_filter = wr & (wb_adr_i == lcs_pkg::ADDR_EVT_FILTER) & wb_sel_i[0];
  wire wr_status = wr & (wb_adr_i == lcs_pkg::ADDR_IRQ_STATUS) & wb_sel_i[0];
  wire wr_mask = wr & (wb_adr_i == lcs_pkg::ADDR_IRQ_MASK) & wb_sel_i[0];
  wire wr_level = wr & (wb_adr_i == lcs_pkg::ADDR_LEVEL) & wb_sel_i[0];
  wire wr_level_hi = wr & (wb_adr_i == lcs_pkg::ADDR_LEVEL) & wb_sel_i[1];

  assign label_word = label_hit ? {label_mem[label_base + 8'h03], label_mem[label_base + 8'h02],
    label_mem[label_base + 8'h01], label_mem[label_base]} : 32'h0000_0000;

  always_comb begin
    rd_data = 32'h0000_0000;
    case (wb_adr_i)
      lcs_pkg::ADDR_STATE: rd_data[NUM_SW-1:0] = state_reg;
      lcs_pkg::ADDR_EVT_FILTER: rd_data[1:0] = filter_reg;
      lcs_pkg::ADDR_IRQ_STATUS: rd_data[lcs_pkg::IRQ_W-1:0] = irq_status_reg;
      lcs_pkg::ADDR_IRQ_MASK: rd_data[lcs_pkg::IRQ_W-1:0] = irq_mask_reg;
      lcs_pkg::ADDR_EVT_CODE: rd_data[4:0] = {evt_valid, evt_code};
      lcs_pkg::ADDR_EVT_STAMP: rd_data[TIME_W-1:0] = evt_stamp;
      lcs_pkg::ADDR_TIME: rd_data[TIME_W-1:0] = time_now;
      lcs_pkg::ADDR_LEVEL: rd_data[2*NUM_SW-1:0] = level_reg;
      default: rd_data = label_word;
    endcase
  end

  // Event capture: the code register is popped by reading it.
  lcs_event_stamp #(
    .NUM_SW(NUM_SW),
    .TIME_W(TIME_W)
  ) u_stamp (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .rise(rise),
    .fall(fall),
    .filter_sel(filter_reg),
    .taken(rd_evt),
    .evt_valid(evt_valid),
    .evt_code(evt_code),
    .evt_stamp(evt_stamp),
    .time_now(time_now),
    .overrun(overrun)
  );

  assign irq_set = {overrun, local_rej & clk_en, (|(rise | fall)) & clk_en};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      switch_out <= '0;
      local_cmd_reject <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      // Outputs go to the relay matrix and user logic in the same cycle as the state, both loaded from state_next.
      switch_out <= state_next;
      local_cmd_reject <= local_rej;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      level_reg <= {NUM_SW{lcs_pkg::LEVEL_RESET}};
      filter_reg <= lcs_pkg::FILTER_RESET;
      irq_mask_reg <= '0;
    end else if (clk_en) begin
      if (wr_filter) filter_reg <= wb_dat_i[1:0];
      if (wr_mask) irq_mask_reg <= wb_dat_i[lcs_pkg::IRQ_W-1:0];
      if (wr_level) level_reg[7:0] <= wb_dat_i[7:0];
      if (wr_level_hi) level_reg[2*NUM_SW-1:8] <= wb_dat_i[2*NUM_SW-1:8];
    end
  end

  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status_reg <= '0;
      event_irq <= 1'b0;
    end else if (clk_en) begin
      irq_status_reg <= (irq_status_reg & ~(wr_status ? wb_dat_i[lcs_pkg::IRQ_W-1:0] : '0))
        | irq_set;
      event_irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Labels live in a byte array; no reset since software always loads them.
  always_ff @(posedge ref_clk) begin
    if (clk_en && wr && label_hit) begin
      for (int b = 0; b < 4; b = b + 1) begin
        if (wb_sel_i[b]) label_mem[label_base + 8'(b)] <= wb_dat_i[8*b +: 8];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en) begin
      wb_ack_o <= wb_req & mapped;
      wb_err_o <= wb_req & ~mapped;
      wb_dat_o <= (wb_req & ~wb_we_i & mapped) ? rd_data : 32'h0000_0000;
    end
  end
endmodule : lcs_switch_bank

// ### lcs_props.sv
// Concurrent checks on the ports of the latching control switch bank.
`timescale 1ns/1ns
module lcs_props #(
  parameter int NUM_SW = 5
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic local_cmd_valid,
  input wire logic remote_cmd_valid,
  input wire logic [2:0] remote_cmd_switch,
  input wire logic remote_cmd_on,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [NUM_SW-1:0] switch_out,
  input wire logic local_cmd_reject
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_idle_hold;
    !local_cmd_valid && !remote_cmd_valid |=> $stable(switch_out);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("switch moved idle");
  property p_remote_set;
    remote_cmd_valid && remote_cmd_switch < NUM_SW
      |=> switch_out[$past(remote_cmd_switch)] == $past(remote_cmd_on);
  endproperty
  a_remote_set: assert property (p_remote_set) else $error("remote ignored");
  property p_one_switch;
    remote_cmd_valid && !local_cmd_valid |=> $onehot0(switch_out ^ $past(switch_out));
  endproperty
  a_one_switch: assert property (p_one_switch) else $error("two switches moved");
  property p_same_state;
    remote_cmd_valid && !local_cmd_valid && remote_cmd_switch < NUM_SW
      && switch_out[remote_cmd_switch] == remote_cmd_on |=> $stable(switch_out);
  endproperty
  a_same_state: assert property (p_same_state) else $error("same state moved");
  property p_reject_cause;
    local_cmd_reject |-> $past(local_cmd_valid);
  endproperty
  a_reject_cause: assert property (p_reject_cause) else $error("stray reject");
  property p_reject_keep;
    local_cmd_reject && !$past(remote_cmd_valid) |-> $stable(switch_out);
  endproperty
  a_reject_keep: assert property (p_reject_keep) else $error("rejected moved");
  property p_bus_answer;
    wb_stb_i && !wb_ack_o && !wb_err_o |=> wb_ack_o ^ wb_err_o;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("no bus answer");
  property p_bus_quiet;
    !wb_stb_i |=> !wb_ack_o && !wb_err_o;
  endproperty
  a_bus_quiet: assert property (p_bus_quiet) else $error("stray bus answer");
endmodule : lcs_props
bind lcs_switch_bank lcs_props #(.NUM_SW(NUM_SW)) u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .local_cmd_valid(local_cmd_valid),
  .remote_cmd_valid(remote_cmd_valid), .remote_cmd_switch(remote_cmd_switch),
  .remote_cmd_on(remote_cmd_on), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .wb_err_o(wb_err_o), .switch_out(switch_out), .local_cmd_reject(local_cmd_reject));

// ### lcs_partner.sv
// Panel operator and remote telecontrol unit issuing switch commands.
`timescale 1ns/1ns
module lcs_partner (
  input wire logic ref_clk,
  output logic vl,
  output logic vr,
  output logic [2:0] sw,
  output logic on,
  output logic [1:0] lv
);
  initial begin
    {vl, vr, sw, on, lv} = 8'h00;
  end
  task automatic cmd(input bit rem, input logic [2:0] s, input logic o, input logic [1:0] l);
    @(posedge ref_clk);
    vl <= !rem;
    vr <= rem;
    sw <= s;
    on <= o;
    lv <= l;
    @(posedge ref_clk);
    vl <= 1'h0;
    vr <= 1'h0;
    // Idle switch and on fields are scrambled so that a stale value never passes for a command; lv is kept.
    sw <= ~s;
    on <= ~o;
  endtask : cmd
endmodule : lcs_partner

// ### tb_top.sv
// Self-checking bench of the latching control switch bank.
`timescale 1ns/1ns
module tb_top;
  logic ref_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, dat;
  logic ack, err, werr, vl, vr, on, rej, irq;
  logic [2:0] sw;
  logic [1:0] lv;
  logic [4:0] so;
  int err_total = 0, checks_done = 0;
  always #10 ref_clk = ~ref_clk;
  lcs_partner p (.ref_clk(ref_clk), .vl(vl), .vr(vr), .sw(sw), .on(on), .lv(lv));
  lcs_switch_bank dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(1'h1),
    .local_cmd_valid(vl), .local_cmd_switch(sw), .local_cmd_on(on),
    .local_session_level(lv), .remote_cmd_valid(vr), .remote_cmd_switch(sw),
    .remote_cmd_on(on), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat), .wb_ack_o(ack), .wb_err_o(err),
    .switch_out(so), .local_cmd_reject(rej), .event_irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    {cyc, stb, we} <= {2'h3, w};
    adr <= a;
    wdat <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (!(ack || err) && n < 50);
    if (n >= 50) err_total++;
    q = dat;
    werr = err;
    {cyc, stb} <= 2'h0;
  endtask : wb
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    #400000;
    err_total++;
    give_verdict();
  end
  initial begin
    logic [31:0] q, t0;
    logic [4:0] m;
    int s, o, chg, lc;
    m = 5'h00;
    chg = 0;
    lc = 0;
    s = $urandom(58416);
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'h1;
    @(posedge ref_clk);
    #1;
    chk(32'(so), 32'h0);
    wb(0, 8'h1c, 32'h0, q);
    chk(q, 32'h2aa);
    // Index 5 is out of range and must leave every switch alone.
    for (int i = 0; i < 40; i++) begin
      s = $urandom_range(5);
      o = $urandom_range(1);
      p.cmd(1, 3'(s), o[0], 2'h0);
      #1;
      if (s < 5 && m[s] != o[0]) chg++;
      if (s < 5) m[s] = o[0];
      chk(32'(so), 32'(m));
    end
    chk(32'(irq), 32'h0);
    wb(1, 8'h0c, 32'h7, q);
    wb(0, 8'h08, 32'h0, q);
    #1;
    chk(32'(irq), 32'(chg > 0));
    chk(q & 32'h1, 32'(chg > 0));
    wb(1, 8'h08, 32'h7, q);
    wb(0, 8'h08, 32'h0, q);
    #1;
    chk(q, 32'h0);
    chk(32'(irq), 32'h0);
    for (int l = 0; l < 4; l++) begin
      p.cmd(0, 3'h1, !m[1], 2'(l));
      #1;
      if (l >= 2) m[1] = !m[1];
      chk(32'(rej), 32'(l < 2));
      chk(32'(so), 32'(m));
    end
    wb(0, 8'h08, 32'h0, q);
    chk(q & 32'h2, 32'h2);
    for (s = 0; s < 5; s++) begin
      wb(1, 8'h04, 32'(s % 4), q);
      for (int k = 0; k < 2; k++) begin
        wb(0, 8'h10, 32'h0, q);
        wb(0, 8'h18, 32'h0, t0);
        p.cmd(1, 3'(s), !m[s], 2'h0);
        m[s] = !m[s];
        o = (s % 4 == 1) ? m[s] : (s % 4 == 2) ? !m[s] : 1;
        wb(0, 8'h14, 32'h0, q);
        if (o) chk(32'(q - t0 - 1 < 8), 32'h1);
        // A filtered-out event leaves the last stored code in place, flagged invalid.
        if (o) lc = 2 * s + !m[s];
        wb(0, 8'h10, 32'h0, q);
        chk(q, o ? 32'h10 + lc : 32'(lc));
      end
    end
    t0 = $urandom();
    wb(1, 8'h5c, t0, q);
    wb(0, 8'h5c, 32'h0, q);
    chk(q, t0);
    wb(1, 8'hdc, ~t0, q);
    wb(0, 8'hdc, 32'h0, q);
    chk(q, ~t0);
    wb(0, 8'h5c, 32'h0, q);
    chk(q, t0);
    wb(0, 8'hf0, 32'h0, q);
    chk(32'(werr), 32'h1);
    wb(1, 8'h00, 32'h0, q);
    chk(32'(so), 32'(m));
    give_verdict();
  end
endmodule : tb_top
